// ==== hw/cec_core_event_ctrl.v ====
// Purpose: core event controller with a system interrupt stage in front
// Assumes: single clock aclk, synchronous active-low aresetn, ce freezes
// Notes:   registers reached over AXI4-Lite; sequencer on plain ports
//
// Summary of operation
// RULE1 - Sixteen fixed levels, 0 highest; 7 to 15 general purpose.
// RULE2 - Latch, mask and pending registers are sixteen bits, one per level.
// RULE3 - Latch bit sets on capture, clears when the event is accepted.
// RULE4 - Software writes a latch bit only while its mask bit is clear.
// RULE5 - Set mask bit lets the event through; clear bit blocks but latches.
// RULE6 - Mask register is accessible only in supervisor mode.
// RULE7 - Global enable for general levels, set and cleared by instructions.
// RULE8 - Pending bits show serviced or nested events; read-only, supervisor.
// RULE9 - Stage has three 32-bit control/status registers, bit per source.
// RULE10 - Higher priority preempts lower; several routines may be active.
// RULE11 - Peripheral requests routed to general levels via assignment regs.
// RULE12 - Accept best latched unmasked level outranking all pending levels.
// RULE13 - Return clears the highest-priority pending bit.
//
// The address map and the AXI4-Lite interface to the registers were decided locally.
`include "cec_map.vh"
`timescale 1ns/1ps
`default_nettype none

module cec_core_event_ctrl #(
  parameter NSRC = 8
) (
  input wire aclk,
  input wire aresetn,
  input wire ce,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [6:0] core_events,
  input wire [NSRC-1:0] periph_irq,
  input wire supervisor,
  input wire global_irq_on_instr,
  input wire global_irq_off_instr,
  input wire event_return,
  output reg event_take,
  output reg [3:0] event_level
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Index of the lowest set bit, i.e. highest priority; 4'hf if none
  function [3:0] top_level;
    input [15:0] v;
    integer i;
    begin
      top_level = 4'hf;
      for (i = 15; i >= 0; i = i - 1)
        if (v[i]) top_level = i[3:0];
    end
  endfunction

  // Byte-lane merge for a 32-bit register
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] st;
    integer b;
    begin
      merge = old;
      for (b = 0; b < 4; b = b + 1)
        if (st[b]) merge[b*8 +: 8] = nw[b*8 +: 8];
    end
  endfunction

  // ----------------------------------------------------------------
  // Input synchronisers for pins and peripheral requests
  // ----------------------------------------------------------------
  reg [6:0] ev_s1_q;
  reg [6:0] ev_s2_q;
  reg [NSRC-1:0] pi_s1_q;
  reg [NSRC-1:0] pi_s2_q;
  reg [6:0] ev_prev_q;

  // Two stages; only the second stage is looked at
  always @(posedge aclk) begin
    if (!aresetn) begin
      ev_s1_q <= 7'h00;
      ev_s2_q <= 7'h00;
      pi_s1_q <= {NSRC{1'b0}};
      pi_s2_q <= {NSRC{1'b0}};
      ev_prev_q <= 7'h00;
    end else if (ce) begin
      ev_s1_q <= core_events;
      ev_s2_q <= ev_s1_q;
      pi_s1_q <= periph_irq;
      pi_s2_q <= pi_s1_q;
      ev_prev_q <= ev_s2_q;
    end
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg [15:0] latch_q; // RULE2
  reg [15:0] mask_q;
  reg [15:0] pend_q;
  reg gen_en_q;
  reg [31:0] sic_en_q;
  reg [31:0] sic_stat_q;
  reg [31:0] sic_wake_q;
  reg [4*NSRC-1:0] assign_q;
  reg [31:0] aw_q;
  reg aw_ok_q;
  reg [31:0] wd_q;
  reg [3:0] ws_q;
  reg wd_ok_q;

  // Core edge events: bit k maps to levels 0..3,5,6 (4 reserved)
  wire [15:0] core_rise;
  assign core_rise = {9'h000, ev_s2_q[5:4] & ~ev_prev_q[5:4], 1'b0,
    ev_s2_q[3:0] & ~ev_prev_q[3:0]}; // RULE1

  // Routing of enabled peripheral sources onto general levels
  reg [15:0] gp_req;
  integer s;
  always @* begin
    gp_req = 16'h0000;
    for (s = 0; s < NSRC; s = s + 1)
      if (pi_s2_q[s] && sic_en_q[s])
        gp_req[`CEC_LVL_GP_FIRST + assign_q[s*4 +: 3]] = 1'b1; // RULE11
  end

  // Arbitration: best latched, unmasked, gated level beats pending
  wire [15:0] gate;
  wire [15:0] ready_v;
  wire [3:0] best;
  wire [3:0] cur;
  wire take;
  assign gate = gen_en_q ? 16'hffff : ~`CEC_GP_MASK; // RULE7
  assign ready_v = latch_q & mask_q & gate; // RULE5
  assign best = top_level(ready_v);
  assign cur = top_level(pend_q);
  assign take = (|ready_v) &&
    (pend_q == 16'h0000 || best < cur); // RULE12 RULE10

  // ----------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------
  wire do_wr;
  wire [7:0] wa;
  wire sup;
  assign do_wr = aw_ok_q && wd_ok_q && !s_axi_bvalid;
  assign wa = aw_q[7:0];
  assign sup = supervisor;
  reg wr_hit;
  always @* begin
    if (wa == `CEC_OFF_LATCH) wr_hit = 1'b1;
    else if (wa == `CEC_OFF_MASK) wr_hit = sup; // RULE6
    else if (wa == `CEC_OFF_CTRL) wr_hit = 1'b1;
    else if (wa == `CEC_OFF_SIC_EN) wr_hit = 1'b1;
    else if (wa == `CEC_OFF_SIC_WAKE) wr_hit = 1'b1;
    else if (wa >= `CEC_OFF_ASSIGN0 && wa < `CEC_OFF_ASSIGN0 + 8'h04 *
      NSRC[7:0] / 8'h08 && wa[1:0] == 2'b00) wr_hit = 1'b1;
    else wr_hit = 1'b0;
  end

  // Handshake capture and all register updates
  integer k;
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CEC_RESP_OKAY;
      aw_ok_q <= 1'b0;
      wd_ok_q <= 1'b0;
      aw_q <= 32'h00000000;
      wd_q <= 32'h00000000;
      ws_q <= 4'h0;
      latch_q <= 16'h0000;
      mask_q <= `CEC_MASK_RST;
      pend_q <= 16'h0000;
      gen_en_q <= 1'b0;
      sic_en_q <= 32'h00000000;
      sic_stat_q <= 32'h00000000;
      sic_wake_q <= 32'h00000000;
      assign_q <= {(NSRC/8){`CEC_ASSIGN_RST}};
      event_take <= 1'b0;
      event_level <= 4'h0;
    end else if (ce) begin
      s_axi_awready <= !aw_ok_q && s_axi_awvalid && !s_axi_awready;
      s_axi_wready <= !wd_ok_q && s_axi_wvalid && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= s_axi_awaddr;
        aw_ok_q <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wd_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
        wd_ok_q <= 1'b1;
      end
      if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
      // Peripheral status is raw request state per source
      sic_stat_q <= {{(32-NSRC){1'b0}}, pi_s2_q}; // RULE9
      // Global enable instructions; off wins if both
      if (global_irq_off_instr) gen_en_q <= 1'b0; // RULE7
      else if (global_irq_on_instr) gen_en_q <= 1'b1; // RULE7
      // Register writes go first so hardware events below win
      if (do_wr) begin
        aw_ok_q <= 1'b0;
        wd_ok_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `CEC_RESP_OKAY : `CEC_RESP_SLVERR;
        if (wa == `CEC_OFF_LATCH) begin
          // Masked bits only; the reserved level can never be set
          for (k = 0; k < 16; k = k + 1)
            if (!mask_q[k] && ws_q[k/8] && k != `CEC_LVL_RSVD)
              latch_q[k] <= wd_q[k]; // RULE4 RULE1
        end else if (wa == `CEC_OFF_MASK && sup) begin
          mask_q[7:0] <= ws_q[0] ? wd_q[7:0] : mask_q[7:0]; // RULE6
          mask_q[15:8] <= ws_q[1] ? wd_q[15:8] : mask_q[15:8];
        end else if (wa == `CEC_OFF_CTRL) begin
          if (ws_q[0]) gen_en_q <= wd_q[`CEC_CTRL_GEN_BIT];
        end else if (wa == `CEC_OFF_SIC_EN) begin
          sic_en_q <= merge(sic_en_q, wd_q, ws_q); // RULE9
        end else if (wa == `CEC_OFF_SIC_WAKE) begin
          sic_wake_q <= merge(sic_wake_q, wd_q, ws_q); // RULE9
        end else if (wr_hit) begin
          assign_q[(wa - `CEC_OFF_ASSIGN0) * 8 +: 32] <=
            merge(assign_q[(wa - `CEC_OFF_ASSIGN0) * 8 +: 32], wd_q,
            ws_q); // RULE11
        end
      end
      // Capture sets, acceptance clears; a new capture beats the clear
      for (k = 0; k < 16; k = k + 1) begin
        if (take && best == k[3:0]) latch_q[k] <= 1'b0; // RULE3
        if (core_rise[k] || gp_req[k]) latch_q[k] <= 1'b1; // RULE3
      end
      // Pending: return clears top bit, acceptance sets new one
      for (k = 0; k < 16; k = k + 1) begin
        if (event_return && pend_q != 16'h0000 && cur == k[3:0])
          pend_q[k] <= 1'b0; // RULE13
        if (take && best == k[3:0]) pend_q[k] <= 1'b1; // RULE8 RULE12
      end
      event_take <= take;
      event_level <= take ? best : event_level;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------
  wire [7:0] ra;
  assign ra = s_axi_araddr[7:0];
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `CEC_RESP_OKAY;
    end else if (ce) begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_rvalid && s_axi_rready) s_axi_rvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `CEC_RESP_OKAY;
        s_axi_rdata <= 32'h00000000;
        if (ra == `CEC_OFF_LATCH) s_axi_rdata <= {16'h0000, latch_q};
        else if (ra == `CEC_OFF_MASK && sup)
          s_axi_rdata <= {16'h0000, mask_q}; // RULE6
        else if (ra == `CEC_OFF_PEND && sup)
          s_axi_rdata <= {16'h0000, pend_q}; // RULE8
        else if (ra == `CEC_OFF_CTRL)
          s_axi_rdata <= {30'h00000000, sup, gen_en_q};
        else if (ra == `CEC_OFF_SIC_EN) s_axi_rdata <= sic_en_q;
        else if (ra == `CEC_OFF_SIC_STAT) s_axi_rdata <= sic_stat_q;
        else if (ra == `CEC_OFF_SIC_WAKE) s_axi_rdata <= sic_wake_q;
        else if (ra >= `CEC_OFF_ASSIGN0 && ra < `CEC_OFF_ASSIGN0 + 8'h04 *
          NSRC[7:0] / 8'h08 && ra[1:0] == 2'b00)
          s_axi_rdata <= assign_q[(ra - `CEC_OFF_ASSIGN0) * 8 +: 32];
        else s_axi_rresp <= `CEC_RESP_SLVERR;
      end
    end
  end

endmodule // cec_core_event_ctrl

`default_nettype wire

// ==== include/cec_map.vh ====
// Purpose: register offsets, field positions and reset values for the
//          core event controller and its system interrupt stage
// Assumes: AXI4-Lite, 32-bit data, one aligned word per register
// Notes:   guarded against double inclusion
`ifndef CEC_MAP_VH
`define CEC_MAP_VH

// ------------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------------
`define CEC_OFF_LATCH 8'h00
`define CEC_OFF_MASK 8'h04
`define CEC_OFF_PEND 8'h08
`define CEC_OFF_CTRL 8'h0c
`define CEC_OFF_SIC_EN 8'h10
`define CEC_OFF_SIC_STAT 8'h14
`define CEC_OFF_SIC_WAKE 8'h18
`define CEC_OFF_ASSIGN0 8'h20

// ------------------------------------------------------------------
// Fields and reset values
// ------------------------------------------------------------------
`define CEC_CTRL_GEN_BIT 0
`define CEC_CTRL_SUP_BIT 1
`define CEC_LVL_GP_FIRST 7
`define CEC_LVL_RSVD 4
`define CEC_MASK_RST 16'h001f
`define CEC_GP_MASK 16'hff80
`define CEC_ASSIGN_RST 32'h76543210
`define CEC_RESP_OKAY 2'b00
`define CEC_RESP_SLVERR 2'b10

`endif

// ==== testbench/cec_ev_checker.sv ====
// Purpose: port checks for the core event controller
// Assumes: one clock, ce held high
// Notes: keeps a shadow of the levels in service
`timescale 1ns/1ps
`default_nettype none
module cec_ev_checker #(parameter NSRC = 8) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic supervisor,
  input wire logic event_return,
  input wire logic event_take,
  input wire logic [3:0] event_level
);
  logic [15:0] pm_q;
  logic [15:0] pm_n;
  logic [4:0] top;
  logic [4:0] topn;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Shadow stack; a return ends the best level, new take included
  always_comb begin
    pm_n = pm_q;
    if (event_take)
      pm_n[event_level] = 1'b1;
    top = 5'd16;
    topn = 5'd16;
    for (int i = 15; i >= 0; i--) begin
      if (pm_q[i])
        top = 5'(i);
      if (pm_n[i])
        topn = 5'(i);
    end
    if (event_return && !topn[4])
      pm_n[topn[3:0]] = 1'b0;
  end
  always_ff @(posedge aclk)
    if (!aresetn)
      pm_q <= 16'h0000;
    else if (ce)
      pm_q <= pm_n;
  // Privileged read: handshake out of supervisor mode
  sequence ar_hs;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence priv_rd;
    ar_hs ##0 (!supervisor && s_axi_araddr[7:0] inside {8'h04, 8'h08});
  endsequence
  a_level_legal: assert property (
    event_take |-> event_level != 4'h4) else $error("reserved level");
  a_nest_rank: assert property (
    event_take |-> {1'b0, event_level} < top) else $error("bad rank");
  a_priv_read: assert property (
    priv_rd |=> s_axi_rvalid && s_axi_rresp == 2'b10 && s_axi_rdata == 0)
    else $error("privileged read let through");
  a_read_lat: assert property (ar_hs |=> s_axi_rvalid)
    else $error("late read data");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read dropped");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("resp dropped");
  a_level_hold: assert property ($changed(event_level) |-> event_take)
    else $error("level moved without take");
  a_reset_quiet: assert property (disable iff (1'b0) !aresetn |=>
    !event_take && !s_axi_bvalid && !s_axi_rvalid) else $error("reset");
endmodule // cec_ev_checker
bind cec_core_event_ctrl cec_ev_checker #(.NSRC(NSRC)) u_chk (.*);
`default_nettype wire

// ==== testbench/cec_seq_model.sv ====
// Purpose: sequencer stand-in answering accepted events
// Assumes: one return per accepted event
// Notes: slow stretches service so nesting shows
`timescale 1ns/1ps
`default_nettype none
module cec_seq_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic slow,
  input wire logic event_take,
  output var logic event_return
);
  logic [3:0] depth_q;
  logic [5:0] wait_q;
  logic due;
  logic go;
  assign due = wait_q == 6'h0 && depth_q != 4'h0;
  assign go = due || (event_take && depth_q == 4'h0);
  // Routines in service; one ends after each delay
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      depth_q <= 4'h0;
      wait_q <= 6'h0;
      event_return <= 1'b0;
    end else begin
      depth_q <= depth_q + {3'h0, event_take} - {3'h0, due};
      if (go)
        wait_q <= slow ? 6'd40 : 6'd2;
      else if (wait_q != 6'h0)
        wait_q <= wait_q - 6'h1;
      event_return <= due;
    end
  end
endmodule // cec_seq_model
`default_nettype wire

// ==== testbench/tb.sv ====
// Purpose: self-checking bench for the core event controller
// Assumes: ce high except one freeze check, all byte lanes written
// Notes: random bursts come from seed 79
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic aclk, aresetn, ce, supervisor, slow;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb, event_level, takes[$];
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, event_take, event_return;
  logic global_irq_on_instr, global_irq_off_instr;
  logic [6:0] core_events, c;
  logic [7:0] periph_irq, p;
  int n_mismatch = 0, n_compared = 0, seed = 79;
  cec_core_event_ctrl #(.NSRC(8)) dut (.*);
  cec_seq_model seq (.aclk(aclk), .aresetn(aresetn), .slow(slow),
    .event_take(event_take), .event_return(event_return));
  // Clock, and a log of accepted levels
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk)
    if (event_take === 1'b1)
      takes.push_back(event_level);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic hang(input int n);
    if (n >= 999) begin
      n_mismatch++;
      $display("unexpected at %0t: no answer", $time);
      end_of_test();
    end
  endtask
  // One bus cycle; read data is compared with d
  task automatic ax(input logic w, input logic [7:0] a,
      input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    s_axi_awaddr <= {24'h0, a};
    s_axi_araddr <= {24'h0, a};
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
    {s_axi_arvalid, s_axi_rready} <= {2{!w}};
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end while (!(w ? s_axi_bvalid : s_axi_rvalid) && n < 999);
    rs = w ? s_axi_bresp : s_axi_rresp;
    rd = s_axi_rdata;
    {s_axi_bready, s_axi_rready} <= 2'b00;
    @(posedge aclk);
    hang(n);
    chk({30'h0, rs}, {30'h0, er});
    if (!w)
      chk(rd, d);
  endtask
  // One-cycle pulses on the event pins and instruction strobes
  task automatic fire(input logic [1:0] g);
    core_events <= c;
    periph_irq <= p;
    {global_irq_on_instr, global_irq_off_instr} <= g;
    @(posedge aclk);
    {core_events, periph_irq} <= 15'h0;
    {global_irq_on_instr, global_irq_off_instr} <= 2'b00;
    @(posedge aclk);
  endtask
  // Wait for k takes, and with dr until every routine has ended
  task automatic waitk(input int k, input logic dr);
    int n;
    n = 0;
    // A take seen at this edge still counts as in service
    while ((takes.size() < k ||
        (dr && (seq.depth_q != 0 || event_take))) && n < 999) begin
      @(posedge aclk);
      n++;
    end
    hang(n);
  endtask
  task automatic chkt(input logic [15:0] m);
    for (int i = 0; i < 16; i++)
      if (m[i])
        chk({28'h0, takes.pop_front()}, 32'(i));
    chk(32'(takes.size()), 32'h0);
  endtask
  function automatic logic [15:0] lv(input logic [6:0] cv,
      input logic [7:0] pv);
    return {1'b0, pv, cv[5:4], 1'b0, cv[3:0]};
  endfunction
  // Reset, directed cases, random bursts, then routing and freeze cases
  initial begin
    {ce, supervisor, slow, aresetn, s_axi_wstrb} = 8'hef;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b000;
    {s_axi_arvalid, s_axi_rready, c, p} = 17'h0;
    {global_irq_on_instr, global_irq_off_instr} = 2'b00;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    {core_events, periph_irq} = 15'h0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    ax(0, 8'h00, 32'h0, 2'b00);
    ax(0, 8'h04, 32'h1f, 2'b00);
    ax(0, 8'h08, 32'h0, 2'b00);
    ax(0, 8'h1c, 32'h0, 2'b10);
    ax(0, 8'h0c, 32'h2, 2'b00);
    ax(0, 8'h14, 32'h0, 2'b00);
    ax(1, 8'h18, 32'ha5c30f96, 2'b00);
    ax(0, 8'h18, 32'ha5c30f96, 2'b00);
    supervisor <= 1'b0;
    ax(0, 8'h04, 32'h0, 2'b10);
    ax(1, 8'h04, 32'hffff, 2'b10);
    supervisor <= 1'b1;
    ax(0, 8'h04, 32'h1f, 2'b00);
    ax(1, 8'h00, 32'h0201, 2'b00);
    ax(1, 8'h10, 32'hff, 2'b00);
    ax(1, 8'h04, 32'hffff, 2'b00);
    ax(0, 8'h00, 32'h0200, 2'b00);
    chk(32'(takes.size()), 32'h0);
    fire(2'b10);
    waitk(1, 0);
    ax(0, 8'h00, 32'h0, 2'b00);
    ax(0, 8'h08, 32'h0200, 2'b00);
    waitk(1, 1);
    chkt(16'h0200);
    p = 8'h20;
    fire(2'b00);
    waitk(1, 0);
    {c, p} = {7'h04, 8'h00};
    fire(2'b00);
    waitk(2, 0);
    ax(0, 8'h08, 32'h1004, 2'b00);
    waitk(2, 1);
    chk({28'h0, takes.pop_front()}, 32'd12);
    chk({28'h0, takes.pop_front()}, 32'd2);
    for (int r = 0; r < 24; r++) begin
      c = 7'($random(seed)) & 7'h3f;
      p = 8'($random(seed));
      slow <= 1'($random(seed));
      fire(2'b00);
      waitk($countones(lv(c, p)), 1);
      chkt(lv(c, p));
    end
    ax(1, 8'h20, 32'h76543217, 2'b00);
    {c, p} = {7'h00, 8'h01};
    fire(2'b01);
    repeat (10) @(posedge aclk);
    chk(32'(takes.size()), 32'h0);
    p = 8'h00;
    // Enable strobe while frozen must be lost
    ce <= 1'b0;
    fire(2'b10);
    repeat (4) @(posedge aclk);
    chk(32'(takes.size()), 32'h0);
    ce <= 1'b1;
    fire(2'b10);
    waitk(1, 1);
    chkt(16'h4000);
    end_of_test();
  end
endmodule // tb
`default_nettype wire
